/* File: bit_rate_gen.sv */
/*
 * One channel's bit rate generator: prescaler, divisor counter and
 * per-bit phase counter, each emitting one-cycle enable pulses.
 * Assumes divisor and select inputs come from registers on clk_in.
 */
`timescale 1ns/1ps
`include "serial_pin_consts.svh"

module bit_rate_gen
	import serial_pin_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic restart_in,
	input wire byte_t divisor_in,
	input wire prescale_t prescale_sel_in,
	input wire logic sync_mode_in,
	output logic base_tick_out,
	output logic bit_tick_out
);

	logic [5:0] pre_cnt_ff;
	logic [5:0] pre_last;
	logic pre_tick;
	byte_t div_cnt_ff;
	logic brg_tick;
	logic [4:0] phase_cnt_ff;
	logic [4:0] phase_last;

	always_comb begin
		unique case (prescale_sel_in)
			2'h0: pre_last = `PRE_LAST_0;
			2'h1: pre_last = `PRE_LAST_1;
			2'h2: pre_last = `PRE_LAST_2;
			2'h3: pre_last = `PRE_LAST_3;
		endcase
	end

	assign pre_tick = (pre_cnt_ff >= pre_last);
	assign brg_tick = pre_tick && (div_cnt_ff >= divisor_in);
	assign phase_last = sync_mode_in ? `TICKS_PER_BIT_SYNC : `TICKS_PER_BIT_ASYNC;

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			pre_cnt_ff <= 6'h00;
		end else if (restart_in || pre_tick) begin
			pre_cnt_ff <= 6'h00;
		end else begin
			pre_cnt_ff <= pre_cnt_ff + 6'h01;
		end
	end

	// divisor counter runs N+1 prescaled ticks per generator tick
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			div_cnt_ff <= 8'h00;
		end else if (restart_in || brg_tick) begin
			div_cnt_ff <= 8'h00;
		end else if (pre_tick) begin
			div_cnt_ff <= div_cnt_ff + 8'h01;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			phase_cnt_ff <= 5'h00;
		end else if (restart_in) begin
			phase_cnt_ff <= 5'h00;
		end else if (brg_tick) begin
			phase_cnt_ff <= (phase_cnt_ff >= phase_last) ? 5'h00 : phase_cnt_ff + 5'h01;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			base_tick_out <= 1'b0;
			bit_tick_out <= 1'b0;
		end else begin
			base_tick_out <= brg_tick && !restart_in;
			bit_tick_out <= brg_tick && !restart_in && (phase_cnt_ff >= phase_last);
		end
	end

endmodule : bit_rate_gen

/* File: pin_partner.sv */
/* partner: far side of the clock and receive pins.
   assumes the bench sets external levels between clock edges. */
`timescale 1ns/1ps
module pin_partner (
	input wire logic clk_in,
	input wire logic sck_oe_in,
	input wire logic sck_value_in,
	input wire logic ext_drive_in,
	input wire logic ext_level_in,
	input wire logic rx_drive_in,
	input wire logic rx_level_in,
	output logic sck_line_out,
	output logic rxd_line_out
);
	logic wander_ff;
	initial wander_ff = 1'b0;
	// an undriven line shows a changing level, never a held one
	always @(posedge clk_in) begin
		wander_ff <= ~wander_ff;
	end
	assign sck_line_out = sck_oe_in ? sck_value_in : (ext_drive_in ? ext_level_in : wander_ff);
	assign rxd_line_out = rx_drive_in ? rx_level_in : ~wander_ff;
endmodule : pin_partner

/* File: serial_pin_consts.svh */
/*
 * Constants for the serial pin port and bit rate generator: register
 * indices, field positions, reset values and divider counts.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef SERIAL_PIN_CONSTS_SVH
`define SERIAL_PIN_CONSTS_SVH

// register indices on the plain register port
`define OFS_PIN_MODE_CONTROL 4'h0
`define OFS_PIN_DATA 4'h1
`define OFS_CH0_MODE 4'h2
`define OFS_CH0_CONTROL 4'h3
`define OFS_CH0_DIVISOR 4'h4
`define OFS_CH1_MODE 4'h5
`define OFS_CH1_DIVISOR 4'h6
`define OFS_PORT_STATUS 4'h7

// reset values
`define RST_PIN_MODE_CONTROL 16'hA888
`define RST_PIN_DATA 8'h00
`define RST_DIVISOR 8'hFF
`define RST_MODE 8'h00
`define RST_CONTROL 8'h00

// pin mode control fields
`define POS_CLKPIN_MODE_HI 3
`define POS_CLKPIN_MODE_LO 2
`define POS_TXPIN_MODE_HI 1
`define POS_TXPIN_MODE_LO 0
`define PIN_MODE_OUTPUT 2'h1

// pin data fields
`define POS_CLKPIN_DATA 1
`define POS_BREAK_DATA 0
`define POS_PIN_DATA_RO 7

// serial mode register fields
`define POS_SYNC_SELECT 7
`define POS_PRESCALE_HI 1
`define POS_PRESCALE_LO 0

// serial control register fields
`define POS_TRANSMITTER_ON 5
`define POS_RX_ON 4
`define POS_CLOCK_ENABLE_HI 1
`define POS_CLOCK_ENABLE_LO 0

// status fields
`define POS_ST_CLKPIN_FREE 0
`define POS_ST_TXPIN_FREE 1
`define POS_ST_CLKPIN_LEVEL 2
`define POS_ST_RXPIN_LEVEL 3

// prescaler terminal counts for select 0..3 (divide by 1, 4, 16, 64)
`define PRE_LAST_0 6'h00
`define PRE_LAST_1 6'h03
`define PRE_LAST_2 6'h0F
`define PRE_LAST_3 6'h3F
// generator ticks per bit: 64*2^-1 async, 8*2^-1 sync
`define TICKS_PER_BIT_ASYNC 5'h1F
`define TICKS_PER_BIT_SYNC 5'h03

`endif

/* File: serial_pin_pkg.sv */
/*
 * Types shared by the serial pin port and its bit rate generators.
 * Assumes the constants header is compiled alongside.
 */
package serial_pin_pkg;

	typedef logic [15:0] reg_word_t;
	typedef logic [7:0] byte_t;
	typedef logic [3:0] reg_addr_t;
	typedef logic [1:0] pin_mode_t;
	typedef logic [1:0] prescale_t;

endpackage : serial_pin_pkg

/* File: serial_pin_port.sv */
/*
 * Serial pin port and bit rate generation for one serial channel, plus
 * a second, independent bit rate generator for the neighbouring channel.
 * Assumes a single 125 MHz clock, a plain register port on that clock,
 * standby requests from logic on the same clock, and pins from outside.
 */
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
// How it works
// - clock pin mode 01 drives clock data bit onto pin; 00 leaves it undriven.
// - clock pin mode 10 makes pin an input; reading data bit returns its level.
// - clock pin mode pair resets to upper bit one, lower bit zero.
// - transmit pin mode 01 drives break bit; 00, the reset state, does not.
// - with receiver on, break bit reads receive pin level regardless of mode.
// - break bit power-on value is not to be relied upon.
// - eight-bit divisor with prescaled clock sets the bit rate.
// - divisor register is readable and writable at all times; here writes are ignored while either standby is asserted.
// - divisor goes to all ones on reset, module standby and standby.
// - each channel owns its own generator and divisor register.
// - prescale select 00,01,10,11 gives divide by 1, 4, 16, 64.
// - bit period is (N+1) times 32 or 4 prescaled clocks, async or sync.
// - divisor takes every value 0 to 255, prescale index 0 to 3.
`timescale 1ns/1ps
`include "serial_pin_consts.svh"

module serial_pin_port
	import serial_pin_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic standby_in,
	input wire logic module_standby_in,
	input wire reg_addr_t addr_in,
	input wire reg_word_t wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output reg_word_t rdata_out,
	input wire logic sck_pin_in,
	output logic sck_pin_out,
	output logic sck_pin_oe_out,
	input wire logic rxd_pin_in,
	output logic txd_pin_out,
	output logic txd_port_drive_out,
	output logic ch0_base_tick_out,
	output logic ch0_bit_tick_out,
	output logic ch1_base_tick_out,
	output logic ch1_bit_tick_out
);

	// register contents
	reg_word_t serial_pin_mode_control_ff;
	byte_t serial_pin_data_ff;
	byte_t ch0_serial_mode_register_ff;
	byte_t ch0_serial_control_register_ff;
	byte_t ch0_bit_rate_divisor_ff;
	byte_t ch1_serial_mode_register_ff;
	byte_t ch1_bit_rate_divisor_ff;

	// pin synchronisers
	logic sck_meta_ff;
	logic sck_sync_ff;
	logic rxd_meta_ff;
	logic rxd_sync_ff;

	// decoded controls
	pin_mode_t clkpin_mode;
	pin_mode_t txpin_mode;
	logic clkpin_mode_hi;
	logic clkpin_drive;
	logic txpin_drive;
	logic rx_on_bit;
	logic transmitter_on_bit;
	logic clock_enable_hi;
	logic clock_enable_lo;
	logic sync_select;
	logic standby_any;

	// access decode
	logic wr_pin_mode;
	logic wr_pin_data;
	logic wr_ch0_mode;
	logic wr_ch0_control;
	logic wr_ch0_divisor;
	logic wr_ch1_mode;
	logic wr_ch1_divisor;
	logic ch0_restart;
	logic ch1_restart;

	// read assembly
	byte_t pin_data_view;
	byte_t port_status;
	reg_word_t nxt_rdata;

	// generator outputs
	logic ch0_base_tick;
	logic ch0_bit_tick;
	logic ch1_base_tick;
	logic ch1_bit_tick;

	assign clkpin_mode = {serial_pin_mode_control_ff[`POS_CLKPIN_MODE_HI],
		serial_pin_mode_control_ff[`POS_CLKPIN_MODE_LO]};
	assign txpin_mode = {serial_pin_mode_control_ff[`POS_TXPIN_MODE_HI],
		serial_pin_mode_control_ff[`POS_TXPIN_MODE_LO]};
	assign clkpin_mode_hi = clkpin_mode[1];
	assign clkpin_drive = (clkpin_mode == `PIN_MODE_OUTPUT);
	assign txpin_drive = (txpin_mode == `PIN_MODE_OUTPUT);
	assign rx_on_bit = ch0_serial_control_register_ff[`POS_RX_ON];
	assign transmitter_on_bit = ch0_serial_control_register_ff[`POS_TRANSMITTER_ON];
	assign clock_enable_hi = ch0_serial_control_register_ff[`POS_CLOCK_ENABLE_HI];
	assign clock_enable_lo = ch0_serial_control_register_ff[`POS_CLOCK_ENABLE_LO];
	assign sync_select = ch0_serial_mode_register_ff[`POS_SYNC_SELECT];
	assign standby_any = standby_in || module_standby_in;

	assign wr_pin_mode = wr_in && (addr_in == `OFS_PIN_MODE_CONTROL);
	assign wr_pin_data = wr_in && (addr_in == `OFS_PIN_DATA);
	assign wr_ch0_mode = wr_in && (addr_in == `OFS_CH0_MODE);
	assign wr_ch0_control = wr_in && (addr_in == `OFS_CH0_CONTROL);
	assign wr_ch0_divisor = wr_in && (addr_in == `OFS_CH0_DIVISOR);
	assign wr_ch1_mode = wr_in && (addr_in == `OFS_CH1_MODE);
	assign wr_ch1_divisor = wr_in && (addr_in == `OFS_CH1_DIVISOR);

	// a new divisor or source takes effect from a clean bit boundary
	assign ch0_restart = wr_ch0_divisor || wr_ch0_mode || standby_any;
	assign ch1_restart = wr_ch1_divisor || wr_ch1_mode || standby_any;

	// pins arrive from outside the clock domain
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			sck_meta_ff <= 1'b0;
			sck_sync_ff <= 1'b0;
		end else begin
			sck_meta_ff <= sck_pin_in;
			sck_sync_ff <= sck_meta_ff;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			rxd_meta_ff <= 1'b1;
			rxd_sync_ff <= 1'b1;
		end else begin
			rxd_meta_ff <= rxd_pin_in;
			rxd_sync_ff <= rxd_meta_ff;
		end
	end

	// pin mode control: clock pin starts as input, transmit pin undriven
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			serial_pin_mode_control_ff <= `RST_PIN_MODE_CONTROL;
		end else if (wr_pin_mode) begin
			serial_pin_mode_control_ff <= wdata_in;
		end
	end

	// pin data: top bit is read only; break bit reset value is a don't-care
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			serial_pin_data_ff <= `RST_PIN_DATA;
		end else if (wr_pin_data) begin
			serial_pin_data_ff <= wdata_in[7:0];
			serial_pin_data_ff[`POS_PIN_DATA_RO] <= 1'b0;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			ch0_serial_mode_register_ff <= `RST_MODE;
		end else if (wr_ch0_mode) begin
			ch0_serial_mode_register_ff <= wdata_in[7:0];
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			ch0_serial_control_register_ff <= `RST_CONTROL;
		end else if (wr_ch0_control) begin
			ch0_serial_control_register_ff <= wdata_in[7:0];
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			ch1_serial_mode_register_ff <= `RST_MODE;
		end else if (wr_ch1_mode) begin
			ch1_serial_mode_register_ff <= wdata_in[7:0];
		end
	end

	// divisors: writable only outside standby, forced to all ones in either standby
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			ch0_bit_rate_divisor_ff <= `RST_DIVISOR;
		end else if (standby_any) begin
			ch0_bit_rate_divisor_ff <= `RST_DIVISOR;
		end else if (wr_ch0_divisor) begin
			ch0_bit_rate_divisor_ff <= wdata_in[7:0];
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			ch1_bit_rate_divisor_ff <= `RST_DIVISOR;
		end else if (standby_any) begin
			ch1_bit_rate_divisor_ff <= `RST_DIVISOR;
		end else if (wr_ch1_divisor) begin
			ch1_bit_rate_divisor_ff <= wdata_in[7:0];
		end
	end

	// clock pin: driven only in output mode, otherwise left to the far side
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			sck_pin_oe_out <= 1'b0;
		end else begin
			sck_pin_oe_out <= clkpin_drive;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			sck_pin_out <= 1'b0;
		end else begin
			sck_pin_out <= serial_pin_data_ff[`POS_CLKPIN_DATA];
		end
	end

	// transmit pin: break bit when in port mode, idle mark otherwise
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			txd_port_drive_out <= 1'b0;
		end else begin
			txd_port_drive_out <= txpin_drive;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			txd_pin_out <= 1'b1;
		end else begin
			txd_pin_out <= txpin_drive ? serial_pin_data_ff[`POS_BREAK_DATA] : 1'b1;
		end
	end

	// pin data as software sees it
	always_comb begin
		pin_data_view = serial_pin_data_ff;
		pin_data_view[`POS_PIN_DATA_RO] = 1'b0;
		if (clkpin_mode_hi) begin
			pin_data_view[`POS_CLKPIN_DATA] = sck_sync_ff;
		end
		if (rx_on_bit) begin
			pin_data_view[`POS_BREAK_DATA] = rxd_sync_ff;
		end
	end

	// tells software whether the port pins are free of the serial function
	always_comb begin
		port_status = 8'h00;
		port_status[`POS_ST_CLKPIN_FREE] = !sync_select && !clock_enable_hi && !clock_enable_lo;
		port_status[`POS_ST_TXPIN_FREE] = !transmitter_on_bit;
		port_status[`POS_ST_CLKPIN_LEVEL] = sck_sync_ff;
		port_status[`POS_ST_RXPIN_LEVEL] = rxd_sync_ff;
	end

	always_comb begin
		nxt_rdata = 16'h0000;
		unique case (addr_in)
			`OFS_PIN_MODE_CONTROL: nxt_rdata = serial_pin_mode_control_ff;
			`OFS_PIN_DATA: nxt_rdata = {8'h00, pin_data_view};
			`OFS_CH0_MODE: nxt_rdata = {8'h00, ch0_serial_mode_register_ff};
			`OFS_CH0_CONTROL: nxt_rdata = {8'h00, ch0_serial_control_register_ff};
			`OFS_CH0_DIVISOR: nxt_rdata = {8'h00, ch0_bit_rate_divisor_ff};
			`OFS_CH1_MODE: nxt_rdata = {8'h00, ch1_serial_mode_register_ff};
			`OFS_CH1_DIVISOR: nxt_rdata = {8'h00, ch1_bit_rate_divisor_ff};
			`OFS_PORT_STATUS: nxt_rdata = {8'h00, port_status};
			default: nxt_rdata = 16'h0000;
		endcase
	end

	// read data stand for exactly the cycle after the read strobe
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			rdata_out <= 16'h0000;
		end else if (rd_in) begin
			rdata_out <= nxt_rdata;
		end else begin
			rdata_out <= 16'h0000;
		end
	end

	bit_rate_gen u_ch0_gen (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.restart_in(ch0_restart),
		.divisor_in(ch0_bit_rate_divisor_ff),
		.prescale_sel_in({ch0_serial_mode_register_ff[`POS_PRESCALE_HI],
			ch0_serial_mode_register_ff[`POS_PRESCALE_LO]}),
		.sync_mode_in(sync_select),
		.base_tick_out(ch0_base_tick),
		.bit_tick_out(ch0_bit_tick)
	);

	bit_rate_gen u_ch1_gen (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.restart_in(ch1_restart),
		.divisor_in(ch1_bit_rate_divisor_ff),
		.prescale_sel_in({ch1_serial_mode_register_ff[`POS_PRESCALE_HI],
			ch1_serial_mode_register_ff[`POS_PRESCALE_LO]}),
		.sync_mode_in(ch1_serial_mode_register_ff[`POS_SYNC_SELECT]),
		.base_tick_out(ch1_base_tick),
		.bit_tick_out(ch1_bit_tick)
	);

	// generator ticks leave the block through flip-flops of the top
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			ch0_base_tick_out <= 1'b0;
		end else begin
			ch0_base_tick_out <= ch0_base_tick;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			ch0_bit_tick_out <= 1'b0;
		end else begin
			ch0_bit_tick_out <= ch0_bit_tick;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			ch1_base_tick_out <= 1'b0;
		end else begin
			ch1_base_tick_out <= ch1_base_tick;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			ch1_bit_tick_out <= 1'b0;
		end else begin
			ch1_bit_tick_out <= ch1_bit_tick;
		end
	end

endmodule : serial_pin_port

/* File: serial_pin_properties.sv */
/* checker: port-level assertions for the serial pin port.
   assumes a bind onto serial_pin_port, one clock, async reset. */
`timescale 1ns/1ps
module serial_pin_properties
	import serial_pin_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic standby_in,
	input wire logic module_standby_in,
	input wire reg_addr_t addr_in,
	input wire reg_word_t wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	input wire reg_word_t rdata_out,
	input wire logic sck_pin_in,
	input wire logic sck_pin_out,
	input wire logic sck_pin_oe_out,
	input wire logic rxd_pin_in,
	input wire logic txd_pin_out,
	input wire logic txd_port_drive_out,
	input wire logic ch0_base_tick_out,
	input wire logic ch0_bit_tick_out,
	input wire logic ch1_base_tick_out,
	input wire logic ch1_bit_tick_out
);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (rst_in);

	logic sb;
	logic restart;
	logic [7:0] div_ff;
	logic [1:0] pre_ff;
	logic [15:0] gap_ff;
	logic [1:0] seen_ff;
	logic [15:0] period;

	assign sb = standby_in | module_standby_in;
	assign restart = sb | (wr_in & (addr_in == 4'h2 | addr_in == 4'h4));
	assign period = ({8'h00, div_ff} + 16'h0001) << {pre_ff, 1'b0};

	// shadow of channel 0 divisor and prescale select
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			div_ff <= 8'hFF;
		end else if (sb) begin
			div_ff <= 8'hFF;
		end else if (wr_in && addr_in == 4'h4) begin
			div_ff <= wdata_in[7:0];
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			pre_ff <= 2'h0;
		end else if (wr_in && addr_in == 4'h2) begin
			pre_ff <= wdata_in[1:0];
		end
	end

	// tick spacing is trusted only from the third tick after a restart
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			gap_ff <= 16'h0000;
			seen_ff <= 2'h0;
		end else if (restart) begin
			seen_ff <= 2'h0;
		end else if (ch0_base_tick_out) begin
			gap_ff <= 16'h0001;
			if (seen_ff != 2'h2) begin
				seen_ff <= seen_ff + 2'h1;
			end
		end else begin
			gap_ff <= gap_ff + 16'h0001;
		end
	end

	sequence mode_wr_s;
		wr_in && addr_in == 4'h0 ##1 !(wr_in && addr_in == 4'h0);
	endsequence
	sequence data_wr_s;
		wr_in && addr_in == 4'h1 ##1 !(wr_in && addr_in == 4'h1);
	endsequence
	sequence div_back_s;
		wr_in && addr_in == 4'h4 && !sb ##1 rd_in && addr_in == 4'h4 && !sb;
	endsequence

	sck_oe_a: assert property (mode_wr_s |-> ##2 sck_pin_oe_out == (($past(wdata_in, 3) & 16'h000C) == 16'h0004))
		else $error("clock pin enable wrong after mode write");
	sck_value_a: assert property (data_wr_s |-> ##2 sck_pin_out == (($past(wdata_in, 3) & 16'h0002) != 16'h0000))
		else $error("clock pin value wrong after data write");
	tx_drive_a: assert property (mode_wr_s |-> ##2 txd_port_drive_out == (($past(wdata_in, 3) & 16'h0003) == 16'h0001))
		else $error("transmit pin drive wrong after mode write");
	txd_idle_a: assert property (!txd_port_drive_out |-> txd_pin_out)
		else $error("transmit pin not idle high while undriven");
	reset_pins_a: assert property ($fell(rst_in) |-> !sck_pin_oe_out && !txd_port_drive_out && txd_pin_out)
		else $error("pins not released after reset");
	div_back_a: assert property (div_back_s |=> rdata_out == ($past(wdata_in, 2) & 16'h00FF))
		else $error("divisor readback wrong");
	rdata_idle_a: assert property (!rd_in |=> rdata_out == 16'h0000)
		else $error("read data not zero outside read");
	standby_div_a: assert property (sb ##1 rd_in && addr_in == 4'h4 |=> rdata_out == 16'h00FF)
		else $error("divisor not all ones in standby");
	base_period_a: assert property (ch0_base_tick_out && seen_ff == 2'h2 && !restart |-> gap_ff == period)
		else $error("base tick spacing wrong");
endmodule : serial_pin_properties

/* File: tb_top.sv */
/* testbench: register, pin and bit rate scenarios for the serial pin port.
   assumes the pin partner model and the bound checker. */
`timescale 1ns/1ps
module tb_top
	import serial_pin_pkg::*;
;
	logic clk_in, rst_in, standby_in, module_standby_in, wr_in, rd_in;
	reg_addr_t addr_in;
	reg_word_t wdata_in, rdata_out;
	logic sck_line, sck_pin_out, sck_pin_oe_out, rxd_line, txd_pin_out, txd_port_drive_out;
	logic c0_base, c0_bit, c1_base, c1_bit;
	logic ext_drive, ext_level, rx_drive, rx_level;
	int errors, comparisons;

	serial_pin_port dut_u (.clk_in(clk_in), .rst_in(rst_in), .standby_in(standby_in),
		.module_standby_in(module_standby_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
		.rd_in(rd_in), .rdata_out(rdata_out), .sck_pin_in(sck_line), .sck_pin_out(sck_pin_out),
		.sck_pin_oe_out(sck_pin_oe_out), .rxd_pin_in(rxd_line), .txd_pin_out(txd_pin_out),
		.txd_port_drive_out(txd_port_drive_out), .ch0_base_tick_out(c0_base), .ch0_bit_tick_out(c0_bit),
		.ch1_base_tick_out(c1_base), .ch1_bit_tick_out(c1_bit));
	pin_partner partner_u (.clk_in(clk_in), .sck_oe_in(sck_pin_oe_out), .sck_value_in(sck_pin_out),
		.ext_drive_in(ext_drive), .ext_level_in(ext_level), .rx_drive_in(rx_drive),
		.rx_level_in(rx_level), .sck_line_out(sck_line), .rxd_line_out(rxd_line));

	initial clk_in = 1'b0;
	always #4 clk_in = ~clk_in;

	task automatic check(input string n, input reg_word_t seen, input reg_word_t exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected %s expected %h seen %h", n, exp, seen);
		end
	endtask : check

	task automatic wr(input reg_addr_t a, input reg_word_t d);
		@(posedge clk_in);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge clk_in);
		wr_in <= 1'b0;
	endtask : wr

	task automatic rdc(input string n, input reg_addr_t a, input reg_word_t e);
		@(posedge clk_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clk_in);
		rd_in <= 1'b0;
		@(negedge clk_in);
		check(n, rdata_out, e);
	endtask : rdc

	task automatic settle(input int n);
		repeat (n) @(negedge clk_in);
	endtask : settle

	function automatic logic pick(input int w);
		return w == 0 ? c0_base : (w == 1 ? c0_bit : (w == 2 ? c1_base : c1_bit));
	endfunction : pick

	// cycles between the second and third tick seen
	task automatic gap(input int w, output int p);
		int k;
		k = 0;
		p = 0;
		while (k < 3 && p < 20000) begin
			@(negedge clk_in);
			p++;
			if (pick(w)) begin
				k++;
				if (k < 3) p = 0;
			end
		end
	endtask : gap

	task automatic t_reset;
		rdc("mode control", 4'h0, 16'hA888);
		check("sck oe", 16'(sck_pin_oe_out), 16'h0000);
		rdc("div0", 4'h4, 16'h00FF);
		rdc("div1", 4'h6, 16'h00FF);
		rdc("unmapped", 4'hF, 16'h0000);
	endtask : t_reset

	task automatic t_clock_pin;
		wr(4'h2, 16'h0000);
		wr(4'h3, 16'h0000);
		wr(4'h1, 16'h0002);
		wr(4'h0, 16'h0004);
		settle(3);
		check("sck oe", 16'(sck_pin_oe_out), 16'h0001);
		check("sck line", 16'(sck_line), 16'h0001);
		wr(4'h1, 16'h0000);
		settle(3);
		check("sck line", 16'(sck_line), 16'h0000);
		wr(4'h0, 16'h0000);
		settle(3);
		check("sck oe", 16'(sck_pin_oe_out), 16'h0000);
		wr(4'h0, 16'h0008);
		rx_drive <= 1'b1;
		rx_level <= 1'b1;
		for (int v = 0; v < 2; v++) begin
			ext_drive <= 1'b1;
			ext_level <= v[0];
			settle(4);
			rdc("sck read", 4'h1, 16'(v) << 1);
			rdc("status", 4'h7, 16'h000B | (16'(v) << 2));
		end
		ext_drive <= 1'b0;
	endtask : t_clock_pin

	task automatic t_break;
		wr(4'h0, 16'h0001);
		settle(3);
		check("txd drive", 16'(txd_port_drive_out), 16'h0001);
		check("txd", 16'(txd_pin_out), 16'h0000);
		wr(4'h3, 16'h0010);
		rx_drive <= 1'b1;
		rx_level <= 1'b1;
		settle(4);
		rdc("rx view", 4'h1, 16'h0001);
		rx_level <= 1'b0;
		wr(4'h1, 16'h0001);
		settle(4);
		rdc("rx view", 4'h1, 16'h0000);
		check("txd", 16'(txd_pin_out), 16'h0001);
		wr(4'h0, 16'h0000);
		settle(3);
		check("txd drive", 16'(txd_port_drive_out), 16'h0000);
		wr(4'h3, 16'h0000);
	endtask : t_break

	task automatic t_divisor;
		for (int m = 0; m < 2; m++) begin
			wr(4'h4, 16'h005A);
			wr(4'h6, 16'h0033);
			rdc("div0", 4'h4, 16'h005A);
			rdc("div1", 4'h6, 16'h0033);
			@(posedge clk_in);
			standby_in <= (m == 0);
			module_standby_in <= (m == 1);
			rdc("div0 standby", 4'h4, 16'h00FF);
			rdc("div1 standby", 4'h6, 16'h00FF);
			@(posedge clk_in);
			standby_in <= 1'b0;
			module_standby_in <= 1'b0;
		end
		// write and read with no gap between the strobes
		@(posedge clk_in);
		addr_in <= 4'h4;
		wdata_in <= 16'h00A5;
		wr_in <= 1'b1;
		@(posedge clk_in);
		wr_in <= 1'b0;
		rd_in <= 1'b1;
		@(posedge clk_in);
		rd_in <= 1'b0;
		@(negedge clk_in);
		check("div0 back to back", rdata_out, 16'h00A5);
	endtask : t_divisor

	task automatic t_rate;
		int p;
		byte_t n [4] = '{8'hFF, 8'h01, 8'h02, 8'h03};
		for (int s = 0; s < 4; s++) begin
			wr(4'h2, 16'(s));
			wr(4'h4, {8'h00, n[s]});
			gap(0, p);
			check("base period", 16'(p), 16'((n[s] + 1) << (2 * s)));
		end
		wr(4'h4, 16'h0000);
		for (int y = 0; y < 2; y++) begin
			wr(4'h2, 16'(y) << 7);
			gap(1, p);
			check("bit period", 16'(p), y ? 16'h0004 : 16'h0020);
		end
		wr(4'h5, 16'h0001);
		wr(4'h6, 16'h0002);
		gap(2, p);
		check("ch1 period", 16'(p), 16'h000C);
		gap(3, p);
		check("ch1 bit period", 16'(p), 16'h0180);
		wr(4'h2, 16'h0001);
		wr(4'h4, 16'h00FF);
		settle(300);
		wr(4'h4, 16'h0003);
		p = 0;
		do begin
			@(negedge clk_in);
			p++;
		end while (!pick(0) && p < 2000);
		// (3+1)*4 clocks from the write, plus the generator output flop and the top output flop
		check("restart", 16'(p), 16'h0012);
	endtask : t_rate

	task automatic results;
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : results

	initial begin
		{rst_in, standby_in, module_standby_in, wr_in, rd_in} = 5'h10;
		{ext_drive, ext_level, rx_drive, rx_level} = 4'h0;
		addr_in = 4'h0;
		wdata_in = 16'h0000;
		repeat (5) @(posedge clk_in);
		rst_in <= 1'b0;
		t_reset();
		t_clock_pin();
		t_break();
		t_divisor();
		t_rate();
		results();
	end

	initial begin
		repeat (20000) @(posedge clk_in);
		errors++;
		results();
	end
endmodule : tb_top

bind serial_pin_port serial_pin_properties props_u (.clk_in(clk_in), .rst_in(rst_in), .standby_in(standby_in),
	.module_standby_in(module_standby_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
	.rdata_out(rdata_out), .sck_pin_in(sck_pin_in), .sck_pin_out(sck_pin_out), .sck_pin_oe_out(sck_pin_oe_out),
	.rxd_pin_in(rxd_pin_in), .txd_pin_out(txd_pin_out), .txd_port_drive_out(txd_port_drive_out),
	.ch0_base_tick_out(ch0_base_tick_out), .ch0_bit_tick_out(ch0_bit_tick_out),
	.ch1_base_tick_out(ch1_base_tick_out), .ch1_bit_tick_out(ch1_bit_tick_out));
